// ==== sic_arbiter.sv ====
// priority arbiter: lowest level wins, lowest index breaks ties
`timescale 1ns/1ps
module sic_arbiter #(
  parameter int NUM_IRQ = 32
) (
  input wire logic [NUM_IRQ-1:0] req_in,
  input wire logic [2*NUM_IRQ-1:0] prio_in,
  output logic found_out,
  output logic [4:0] index_out,
  output logic [1:0] level_out
);
  always_comb begin
    found_out = 1'b0;
    index_out = 5'h00;
    level_out = 2'h3;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (req_in[i] && (!found_out || prio_in[2*i +: 2] <= level_out)) begin
        found_out = 1'b1;
        index_out = 5'(i);
        level_out = prio_in[2*i +: 2];
      end
    end
  end
endmodule // sic_arbiter

// ==== sic_cfg.svh ====
// constants for the system-instruction and interrupt-controller block
`ifndef SIC_CFG_SVH
`define SIC_CFG_SVH
`define SIC_OFF_SET_EN 32'hE000E100
`define SIC_OFF_CLR_EN 32'hE000E180
`define SIC_OFF_SET_PEND 32'hE000E200
`define SIC_OFF_CLR_PEND 32'hE000E280
`define SIC_OFF_PRIO_BASE 32'hE000E400
`define SIC_OFF_PRIO_LAST 32'hE000E41C
`define SIC_RESET_WORD 32'h00000000
`define SIC_PRIO_HI 7
`define SIC_PRIO_LO 6
`define SIC_FLAG_HI 31
`define SIC_FLAG_LO 28
`define SIC_SR_SEL_APP_STATUS_VIEW 4'h0
`define SIC_SR_SEL_IRQ_APP_STATUS_VIEW 4'h1
`define SIC_SR_SEL_EXEC_APP_STATUS_VIEW 4'h2
`define SIC_SR_SEL_PSR 4'h3
`define SIC_SR_SEL_IRQ_STATUS_VIEW 4'h5
`define SIC_SR_SEL_EXEC_STATUS_VIEW 4'h6
`define SIC_SR_SEL_IRQ_EXEC_STATUS_VIEW 4'h7
`define SIC_SR_SEL_MSP 4'h8
`define SIC_SR_SEL_PSP 4'h9
`define SIC_SR_SEL_MASK 4'hA
`define SIC_SR_SEL_CTRL 4'hB
`define SIC_EVT_RESET 1'b0
`endif

// ==== sic_core.sv ====
// system-instruction execution and nested interrupt controller
`timescale 1ns/1ps
`include "sic_cfg.svh"
module sic_core #(
  parameter int NUM_IRQ = 32,
  parameter bit WAIT_EVENT_IMPL = 1'b0
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic [NUM_IRQ-1:0] IRQ_IN,
  input wire logic EXT_EVENT_IN,
  input wire logic DEBUG_REQ_IN,
  input wire logic DEBUG_EN_IN,
  input wire logic SEND_ON_PEND_IN,
  input wire logic INSTR_VALID_IN,
  input wire logic [2:0] INSTR_OP_IN,
  input wire logic [3:0] INSTR_SEL_IN,
  input wire logic [31:0] INSTR_SRC_IN,
  input wire logic [3:0] INSTR_RD_IN,
  input wire logic [7:0] INSTR_IMM_IN,
  input wire logic EXC_RETURN_IN,
  input wire logic PPB_SEL_IN,
  input wire logic PPB_WRITE_IN,
  input wire logic [31:0] PPB_ADDR_IN,
  input wire logic [31:0] PPB_WDATA_IN,
  output logic [31:0] PPB_RDATA_OUT,
  output logic PPB_ERR_OUT,
  output logic INSTR_DONE_OUT,
  output logic GPR_WE_OUT,
  output logic [3:0] GPR_RD_OUT,
  output logic [31:0] GPR_DATA_OUT,
  output logic [3:0] FLAGS_OUT,
  output logic INTERRUPT_MASK_OUT,
  output logic [31:0] MAIN_SP_OUT,
  output logic [31:0] PROC_SP_OUT,
  output logic [1:0] CONTROL_OUT,
  output logic SLEEPING_OUT,
  output logic EVENT_OUT,
  output logic EVENT_REG_OUT,
  output logic SVC_TAKEN_OUT,
  output logic [7:0] SVC_IMM_OUT,
  output logic IRQ_TAKEN_OUT,
  output logic [4:0] IRQ_NUM_OUT,
  output logic [5:0] EXC_NUM_OUT,
  output logic [NUM_IRQ-1:0] IRQ_ACTIVE_OUT
);
  localparam logic [5:0] EXC_SVC = 6'h0B;
  localparam logic [5:0] EXC_IRQ0 = 6'h10;

  // no non-maskable line: every source goes through enable and mask
  // pins come from other domains: two flops before use
  logic [NUM_IRQ-1:0] irq_s1_q, irq_s2_q, irq_prev_q;
  logic [2:0] misc_s1_q, misc_s2_q;
  always_ff @(posedge CLK_IN) begin
    irq_s1_q <= IRQ_IN;
    irq_s2_q <= irq_s1_q;
    misc_s1_q <= {EXT_EVENT_IN, DEBUG_REQ_IN, DEBUG_EN_IN};
    misc_s2_q <= misc_s1_q;
    if (RESET_IN) begin
      irq_prev_q <= '0;
    end else begin
      irq_prev_q <= irq_s2_q;
    end
  end
  logic ext_event, debug_req, debug_en;
  assign ext_event = misc_s2_q[2];
  assign debug_req = misc_s2_q[1];
  assign debug_en = misc_s2_q[0];

  // controller state
  logic [NUM_IRQ-1:0] enable_q, pending_q, active_q;
  logic [2*NUM_IRQ-1:0] prio_q;
  logic [1:0] stack_lvl_q;
  logic in_handler_q;
  logic [4:0] cur_irq_q;

  // bus decode
  logic wr_set_en, wr_clr_en, wr_set_pd, wr_clr_pd, wr_prio;
  logic hit_prio;
  logic [2:0] prio_word;
  assign hit_prio = (PPB_ADDR_IN >= `SIC_OFF_PRIO_BASE) &&
    (PPB_ADDR_IN <= `SIC_OFF_PRIO_LAST) && (PPB_ADDR_IN[1:0] == 2'h0);
  assign prio_word = PPB_ADDR_IN[4:2];
  assign wr_set_en = PPB_SEL_IN && PPB_WRITE_IN &&
    PPB_ADDR_IN == `SIC_OFF_SET_EN;
  assign wr_clr_en = PPB_SEL_IN && PPB_WRITE_IN &&
    PPB_ADDR_IN == `SIC_OFF_CLR_EN;
  assign wr_set_pd = PPB_SEL_IN && PPB_WRITE_IN &&
    PPB_ADDR_IN == `SIC_OFF_SET_PEND;
  assign wr_clr_pd = PPB_SEL_IN && PPB_WRITE_IN &&
    PPB_ADDR_IN == `SIC_OFF_CLR_PEND;
  assign wr_prio = PPB_SEL_IN && PPB_WRITE_IN && hit_prio;

  // arbitration over enabled pending lines
  logic arb_found;
  logic [4:0] arb_idx;
  logic [1:0] arb_lvl;
  // enabled lines only, lower level wins
  sic_arbiter #(.NUM_IRQ(NUM_IRQ)) u_arb (
    .req_in(pending_q & enable_q),
    .prio_in(prio_q),
    .found_out(arb_found),
    .index_out(arb_idx),
    .level_out(arb_lvl)
  );

  // would preempt current execution level, ignoring the mask
  logic preempt_ok;
  assign preempt_ok = arb_found && (!in_handler_q || arb_lvl < stack_lvl_q);

  logic [31:0] flags_word_q;
  logic mask_q;
  logic take_irq;
  assign take_irq = preempt_ok && !mask_q;

  // instruction decode
  sic_pkg::sic_op_type op;
  assign op = sic_pkg::sic_op_type'(INSTR_OP_IN);
  logic run_instr;
  sic_pkg::sic_state_type state_q;
  assign run_instr = INSTR_VALID_IN && state_q == sic_pkg::SIC_ST_RUN;

  // pending, active and enable state
  logic [NUM_IRQ-1:0] hw_pend, take_vec, ret_vec;
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_line
      // level while inactive and not being taken, or rising edge
      assign hw_pend[g] = (irq_s2_q[g] && !active_q[g] && !take_vec[g]) ||
        (irq_s2_q[g] && !irq_prev_q[g]);
      assign take_vec[g] = take_irq && arb_idx == 5'(g);
      assign ret_vec[g] = EXC_RETURN_IN && in_handler_q &&
        cur_irq_q == 5'(g);
    end
  endgenerate

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      enable_q <= `SIC_RESET_WORD;
      pending_q <= `SIC_RESET_WORD;
      active_q <= '0;
    end else begin
      if (wr_set_en) begin
        enable_q <= enable_q | PPB_WDATA_IN;
      end else if (wr_clr_en) begin
        enable_q <= enable_q & ~PPB_WDATA_IN;
      end
      // clear-pending touches pending only; hardware set wins
      pending_q <= ((pending_q & ~(wr_clr_pd ? PPB_WDATA_IN : '0))
        & ~take_vec) | hw_pend | (wr_set_pd ? PPB_WDATA_IN : '0);
      active_q <= (active_q | take_vec) & ~ret_vec;
    end
  end

  // only top two bits of each byte kept
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      prio_q <= '0;
    end else if (wr_prio) begin
      for (int b = 0; b < 4; b++) begin
        prio_q[2*(4*prio_word + b) +: 2] <=
          PPB_WDATA_IN[8*b + `SIC_PRIO_LO +: 2];
      end
    end
  end

  // register read path
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h00000000;
    if (hit_prio) begin
      for (int b = 0; b < 4; b++) begin
        rd_d[8*b + `SIC_PRIO_LO +: 2] = prio_q[2*(4*prio_word + b) +: 2];
      end
    end else if (PPB_ADDR_IN == `SIC_OFF_SET_EN ||
                 PPB_ADDR_IN == `SIC_OFF_CLR_EN) begin
      rd_d = enable_q;
    end else if (PPB_ADDR_IN == `SIC_OFF_SET_PEND ||
                 PPB_ADDR_IN == `SIC_OFF_CLR_PEND) begin
      rd_d = pending_q;
    end
  end
  logic mapped;
  assign mapped = hit_prio || PPB_ADDR_IN == `SIC_OFF_SET_EN ||
    PPB_ADDR_IN == `SIC_OFF_CLR_EN || PPB_ADDR_IN == `SIC_OFF_SET_PEND ||
    PPB_ADDR_IN == `SIC_OFF_CLR_PEND;
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PPB_RDATA_OUT <= 32'h00000000;
      PPB_ERR_OUT <= 1'b0;
    end else begin
      PPB_RDATA_OUT <= (PPB_SEL_IN && !PPB_WRITE_IN) ? rd_d : 32'h00000000;
      PPB_ERR_OUT <= PPB_SEL_IN && !mapped;
    end
  end

  // handler nesting: a single saved level keeps the model small
  logic [1:0] saved_lvl_q;
  logic saved_hdl_q;
  logic [4:0] saved_irq_q;
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      in_handler_q <= 1'b0;
      stack_lvl_q <= 2'h0;
      cur_irq_q <= 5'h00;
      saved_lvl_q <= 2'h0;
      saved_hdl_q <= 1'b0;
      saved_irq_q <= 5'h00;
    end else if (take_irq) begin
      // state pushed by hardware on entry
      saved_hdl_q <= in_handler_q && !EXC_RETURN_IN;
      saved_lvl_q <= stack_lvl_q;
      saved_irq_q <= cur_irq_q;
      in_handler_q <= 1'b1;
      stack_lvl_q <= arb_lvl;
      cur_irq_q <= arb_idx;
    end else if (EXC_RETURN_IN && in_handler_q) begin
      in_handler_q <= saved_hdl_q;
      stack_lvl_q <= saved_lvl_q;
      cur_irq_q <= saved_irq_q;
      saved_hdl_q <= 1'b0;
    end
  end

  // special registers
  logic [31:0] msp_q, psp_q;
  logic [1:0] ctrl_q;
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      flags_word_q <= 32'h00000000;
      mask_q <= 1'b0;
      msp_q <= 32'h00000000;
      psp_q <= 32'h00000000;
      ctrl_q <= 2'h0;
    end else if (run_instr && op == sic_pkg::SIC_OP_SRWRITE) begin
      // load selected register; the three app status views and the PSR set flags
      case (INSTR_SEL_IN)
        `SIC_SR_SEL_APP_STATUS_VIEW, `SIC_SR_SEL_IRQ_APP_STATUS_VIEW, `SIC_SR_SEL_EXEC_APP_STATUS_VIEW,
        `SIC_SR_SEL_PSR: begin
          flags_word_q[`SIC_FLAG_HI:`SIC_FLAG_LO] <=
            INSTR_SRC_IN[`SIC_FLAG_HI:`SIC_FLAG_LO];
        end
        `SIC_SR_SEL_MSP: msp_q <= {INSTR_SRC_IN[31:2], 2'h0};
        `SIC_SR_SEL_PSP: psp_q <= {INSTR_SRC_IN[31:2], 2'h0};
        `SIC_SR_SEL_MASK: mask_q <= INSTR_SRC_IN[0];
        `SIC_SR_SEL_CTRL: ctrl_q <= INSTR_SRC_IN[1:0];
        default: mask_q <= mask_q;
      endcase
    end
  end

  // read value of the selected special register
  logic [31:0] sr_val;
  logic [31:0] irq_status_view_val;
  assign irq_status_view_val = in_handler_q ? {26'h0, EXC_IRQ0 + {1'b0, cur_irq_q}}
    : 32'h00000000;
  always_comb begin
    case (INSTR_SEL_IN)
      `SIC_SR_SEL_APP_STATUS_VIEW, `SIC_SR_SEL_EXEC_APP_STATUS_VIEW: sr_val = flags_word_q;
      `SIC_SR_SEL_IRQ_APP_STATUS_VIEW, `SIC_SR_SEL_PSR: sr_val = flags_word_q | irq_status_view_val;
      `SIC_SR_SEL_IRQ_STATUS_VIEW, `SIC_SR_SEL_IRQ_EXEC_STATUS_VIEW: sr_val = irq_status_view_val;
      `SIC_SR_SEL_MSP: sr_val = msp_q;
      `SIC_SR_SEL_PSP: sr_val = psp_q;
      `SIC_SR_SEL_MASK: sr_val = {31'h0, mask_q};
      `SIC_SR_SEL_CTRL: sr_val = {30'h0, ctrl_q};
      default: sr_val = 32'h00000000;
    endcase
  end

  // event register, sleep and instruction completion
  logic event_q;
  logic wake_wirq, wake_wevt, sleep_is_wevt_q;
  // wake on exception, masked-but-preempting pend, any debug request
  assign wake_wirq = preempt_ok || debug_req;
  // wake on unmasked exception, pend with send-on-pend, debug, event
  assign wake_wevt = take_irq || (SEND_ON_PEND_IN && |hw_pend) ||
    (debug_req && debug_en) || ext_event;
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      event_q <= `SIC_EVT_RESET;
      state_q <= sic_pkg::SIC_ST_RUN;
      sleep_is_wevt_q <= 1'b0;
    end else begin
      case (state_q)
        sic_pkg::SIC_ST_RUN: begin
          if (run_instr && op == sic_pkg::SIC_OP_SEV) begin
            event_q <= 1'b1;
          end else if (run_instr && op == sic_pkg::SIC_OP_WEVT &&
                       WAIT_EVENT_IMPL) begin
            if (event_q) begin
              event_q <= 1'b0;
            end else if (!wake_wevt) begin
              state_q <= sic_pkg::SIC_ST_SLEEP;
              sleep_is_wevt_q <= 1'b1;
            end
          end else if (run_instr && op == sic_pkg::SIC_OP_WIRQ &&
                       !wake_wirq) begin
            state_q <= sic_pkg::SIC_ST_SLEEP;
            sleep_is_wevt_q <= 1'b0;
          end else if (ext_event) begin
            event_q <= 1'b1;
          end
        end
        sic_pkg::SIC_ST_SLEEP: begin
          if (sleep_is_wevt_q ? wake_wevt : wake_wirq) begin
            state_q <= sic_pkg::SIC_ST_RUN;
          end
        end
        default: state_q <= sic_pkg::SIC_ST_RUN;
      endcase
    end
  end

  // instruction results; flags only move on a status write
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      INSTR_DONE_OUT <= 1'b0;
      GPR_WE_OUT <= 1'b0;
      GPR_RD_OUT <= 4'h0;
      GPR_DATA_OUT <= 32'h00000000;
      EVENT_OUT <= 1'b0;
      SVC_TAKEN_OUT <= 1'b0;
      SVC_IMM_OUT <= 8'h00;
    end else begin
      // no-op just completes; wait-for-event acts as no-op unless WAIT_EVENT_IMPL is set
      INSTR_DONE_OUT <= run_instr && !(op == sic_pkg::SIC_OP_WIRQ &&
        !wake_wirq) && !(op == sic_pkg::SIC_OP_WEVT && WAIT_EVENT_IMPL &&
        !event_q && !wake_wevt);
      GPR_WE_OUT <= run_instr && op == sic_pkg::SIC_OP_SRREAD;
      GPR_RD_OUT <= INSTR_RD_IN;
      GPR_DATA_OUT <= sr_val;
      EVENT_OUT <= run_instr && op == sic_pkg::SIC_OP_SEV;
      // exception raised, immediate passed along untouched
      SVC_TAKEN_OUT <= run_instr && op == sic_pkg::SIC_OP_SVC;
      SVC_IMM_OUT <= INSTR_IMM_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      IRQ_TAKEN_OUT <= 1'b0;
      IRQ_NUM_OUT <= 5'h00;
      EXC_NUM_OUT <= 6'h00;
      IRQ_ACTIVE_OUT <= '0;
      FLAGS_OUT <= 4'h0;
      INTERRUPT_MASK_OUT <= 1'b0;
      MAIN_SP_OUT <= 32'h00000000;
      PROC_SP_OUT <= 32'h00000000;
      CONTROL_OUT <= 2'h0;
      SLEEPING_OUT <= 1'b0;
      EVENT_REG_OUT <= 1'b0;
    end else begin
      IRQ_TAKEN_OUT <= take_irq;
      IRQ_NUM_OUT <= arb_idx;
      EXC_NUM_OUT <= (run_instr && op == sic_pkg::SIC_OP_SVC) ? EXC_SVC :
        (take_irq ? EXC_IRQ0 + {1'b0, arb_idx} : 6'h00);
      IRQ_ACTIVE_OUT <= active_q;
      FLAGS_OUT <= flags_word_q[`SIC_FLAG_HI:`SIC_FLAG_LO];
      INTERRUPT_MASK_OUT <= mask_q;
      MAIN_SP_OUT <= msp_q;
      PROC_SP_OUT <= psp_q;
      CONTROL_OUT <= ctrl_q;
      SLEEPING_OUT <= state_q == sic_pkg::SIC_ST_SLEEP;
      EVENT_REG_OUT <= event_q;
    end
  end
endmodule // sic_core

// ==== sic_core_props.sv ====
// assertion checker for the system-instruction block
`timescale 1ns/1ps
`include "sic_cfg.svh"
module sic_core_props (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic INSTR_VALID_IN,
  input wire logic [2:0] INSTR_OP_IN,
  input wire logic [3:0] INSTR_SEL_IN,
  input wire logic [31:0] INSTR_SRC_IN,
  input wire logic [3:0] INSTR_RD_IN,
  input wire logic [7:0] INSTR_IMM_IN,
  input wire logic EXC_RETURN_IN,
  input wire logic PPB_SEL_IN,
  input wire logic PPB_WRITE_IN,
  input wire logic [31:0] PPB_ADDR_IN,
  input wire logic [31:0] PPB_RDATA_OUT,
  input wire logic PPB_ERR_OUT,
  input wire logic INSTR_DONE_OUT,
  input wire logic GPR_WE_OUT,
  input wire logic [3:0] GPR_RD_OUT,
  input wire logic [3:0] FLAGS_OUT,
  input wire logic SLEEPING_OUT,
  input wire logic EVENT_OUT,
  input wire logic EVENT_REG_OUT,
  input wire logic SVC_TAKEN_OUT,
  input wire logic [7:0] SVC_IMM_OUT,
  input wire logic IRQ_TAKEN_OUT,
  input wire logic [4:0] IRQ_NUM_OUT,
  input wire logic [5:0] EXC_NUM_OUT
);
  logic go;
  logic prio_rd;
  assign go = INSTR_VALID_IN && !SLEEPING_OUT;
  assign prio_rd = PPB_SEL_IN && !PPB_WRITE_IN &&
    PPB_ADDR_IN >= `SIC_OFF_PRIO_BASE && PPB_ADDR_IN <= `SIC_OFF_PRIO_LAST;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN);
  sev_event_a: assert property (
    go && INSTR_OP_IN == sic_pkg::SIC_OP_SEV |=> EVENT_OUT ##1 EVENT_REG_OUT)
    else $error("event send lost");
  svc_raise_a: assert property (
    go && INSTR_OP_IN == sic_pkg::SIC_OP_SVC
    |=> SVC_TAKEN_OUT && SVC_IMM_OUT == $past(INSTR_IMM_IN))
    else $error("supervisor call lost");
  // a return from a handler is kept out as well; it does not restore flags
  flags_kept_a: assert property (
    go && INSTR_OP_IN != sic_pkg::SIC_OP_SRWRITE && !EXC_RETURN_IN
    ##1 !EXC_RETURN_IN |=> $stable(FLAGS_OUT))
    else $error("flags changed");
  flags_write_a: assert property (
    go && INSTR_OP_IN == sic_pkg::SIC_OP_SRWRITE &&
    INSTR_SEL_IN == `SIC_SR_SEL_APP_STATUS_VIEW
    |-> ##2 FLAGS_OUT == $past(INSTR_SRC_IN[31:28], 2))
    else $error("flags not loaded");
  read_dest_a: assert property (
    go && INSTR_OP_IN == sic_pkg::SIC_OP_SRREAD
    |=> GPR_WE_OUT && GPR_RD_OUT == $past(INSTR_RD_IN))
    else $error("special read result lost");
  nop_quiet_a: assert property (
    go && INSTR_OP_IN == sic_pkg::SIC_OP_NOP
    |=> INSTR_DONE_OUT && !GPR_WE_OUT && !EVENT_OUT && !SVC_TAKEN_OUT)
    else $error("no-operation had an effect");
  wfe_noop_a: assert property (
    go && INSTR_OP_IN == sic_pkg::SIC_OP_WEVT
    |=> INSTR_DONE_OUT && !SLEEPING_OUT)
    else $error("wait for event slept");
  prio_bits_a: assert property (
    prio_rd |=> (PPB_RDATA_OUT & 32'h3F3F3F3F) == 32'h00000000)
    else $error("priority low bits not zero");
  unmapped_err_a: assert property (
    PPB_SEL_IN && PPB_ADDR_IN[31:12] != 20'hE000E
    |=> PPB_ERR_OUT && PPB_RDATA_OUT == 32'h00000000)
    else $error("unmapped access not refused");
  irq_number_a: assert property (
    IRQ_TAKEN_OUT |-> EXC_NUM_OUT == 6'h10 + {1'b0, IRQ_NUM_OUT})
    else $error("exception number wrong");
  reset_clear_a: assert property (
    @(posedge CLK_IN) disable iff (1'b0)
    RESET_IN |=> !SLEEPING_OUT && !EVENT_REG_OUT && !IRQ_TAKEN_OUT &&
    PPB_RDATA_OUT == 32'h00000000)
    else $error("outputs not cleared by reset");
  cover property (go && INSTR_OP_IN == sic_pkg::SIC_OP_SEV);
  cover property (IRQ_TAKEN_OUT);
  cover property ($rose(SLEEPING_OUT));
endmodule // sic_core_props
bind sic_core sic_core_props u_props (
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .INSTR_VALID_IN(INSTR_VALID_IN),
  .INSTR_OP_IN(INSTR_OP_IN), .INSTR_SEL_IN(INSTR_SEL_IN),
  .INSTR_SRC_IN(INSTR_SRC_IN), .INSTR_RD_IN(INSTR_RD_IN),
  .INSTR_IMM_IN(INSTR_IMM_IN), .EXC_RETURN_IN(EXC_RETURN_IN),
  .PPB_SEL_IN(PPB_SEL_IN), .PPB_WRITE_IN(PPB_WRITE_IN),
  .PPB_ADDR_IN(PPB_ADDR_IN), .PPB_RDATA_OUT(PPB_RDATA_OUT),
  .PPB_ERR_OUT(PPB_ERR_OUT), .INSTR_DONE_OUT(INSTR_DONE_OUT),
  .GPR_WE_OUT(GPR_WE_OUT), .GPR_RD_OUT(GPR_RD_OUT), .FLAGS_OUT(FLAGS_OUT),
  .SLEEPING_OUT(SLEEPING_OUT), .EVENT_OUT(EVENT_OUT),
  .EVENT_REG_OUT(EVENT_REG_OUT), .SVC_TAKEN_OUT(SVC_TAKEN_OUT),
  .SVC_IMM_OUT(SVC_IMM_OUT), .IRQ_TAKEN_OUT(IRQ_TAKEN_OUT),
  .IRQ_NUM_OUT(IRQ_NUM_OUT), .EXC_NUM_OUT(EXC_NUM_OUT));

// ==== sic_core_tb.sv ====
// self-checking bench for the system-instruction block
`timescale 1ns/1ps
`include "sic_cfg.svh"
module sic_core_tb;
  logic clk = 1'b0, rst = 1'b1, fire = 1'b0, pls = 1'b0, drop = 1'b0;
  logic ext = 1'b0, dreq = 1'b0, den = 1'b0, sop = 1'b0;
  logic iv = 1'b0, exr = 1'b0, sel = 1'b0, wr = 1'b0;
  logic [4:0] line = 5'h00;
  logic [2:0] op = 3'h0;
  logic [3:0] isel = 4'h0, ird = 4'h0, pv, rg;
  logic [7:0] imm = 8'h00, sv;
  logic [31:0] src = 32'h0, addr = 32'h0, wdat = 32'h0;
  logic [31:0] seed = 32'h00000762, t, r, rv, gv, irq, rdata, gdat, main_stack_pointer, act;
  logic err, re, done, gwe, msk, slp, ev, evr, svt, irt;
  logic [3:0] grd, flg;
  logic [7:0] simm;
  logic [4:0] inum;
  logic [5:0] seen = 6'h00;
  int bad_count = 0, n_tests = 0, cyc = 0, k;
  sic_irq_src src_model (.clk_in(clk), .fire_in(fire), .pulse_in(pls),
    .drop_in(drop), .line_in(line), .irq_out(irq));
  sic_core dut (
    .CLK_IN(clk), .RESET_IN(rst), .IRQ_IN(irq), .EXT_EVENT_IN(ext),
    .DEBUG_REQ_IN(dreq), .DEBUG_EN_IN(den), .SEND_ON_PEND_IN(sop),
    .INSTR_VALID_IN(iv), .INSTR_OP_IN(op), .INSTR_SEL_IN(isel),
    .INSTR_SRC_IN(src), .INSTR_RD_IN(ird), .INSTR_IMM_IN(imm),
    .EXC_RETURN_IN(exr), .PPB_SEL_IN(sel), .PPB_WRITE_IN(wr),
    .PPB_ADDR_IN(addr), .PPB_WDATA_IN(wdat), .PPB_RDATA_OUT(rdata),
    .PPB_ERR_OUT(err), .INSTR_DONE_OUT(done), .GPR_WE_OUT(gwe),
    .GPR_RD_OUT(grd), .GPR_DATA_OUT(gdat), .FLAGS_OUT(flg),
    .INTERRUPT_MASK_OUT(msk), .MAIN_SP_OUT(main_stack_pointer), .PROC_SP_OUT(),
    .CONTROL_OUT(), .SLEEPING_OUT(slp), .EVENT_OUT(ev),
    .EVENT_REG_OUT(evr), .SVC_TAKEN_OUT(svt), .SVC_IMM_OUT(simm),
    .IRQ_TAKEN_OUT(irt), .IRQ_NUM_OUT(inum), .EXC_NUM_OUT(),
    .IRQ_ACTIVE_OUT(act));
  always #5 clk = ~clk;
  // the taken pulse lasts one cycle, so it is latched here for the waits
  always @(posedge clk) if (irt === 1'b1) seen <= {1'b1, inum};
  always @(posedge clk) begin
    cyc++;
    if (cyc > 4000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] pulses(logic [2:0] o);
    return {1'b1, o == sic_pkg::SIC_OP_SEV, o == sic_pkg::SIC_OP_SVC,
      o == sic_pkg::SIC_OP_SRREAD};
  endfunction
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      $display("wrong value %s exp %h got %h", n, e, v);
      bad_count++;
    end
  endtask
  // answers stand one cycle: capture them, then idle a cycle
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    sel = 1'b1; wr = w; addr = a; wdat = d;
    tick();
    rv = rdata; re = err; sel = 1'b0; wr = 1'b0;
    tick();
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e, logic er);
    bus(1'b0, a, 32'h0);
    chk("rdata", e, rv);
    chk("err", {31'h0, er}, {31'h0, re});
  endtask
  task automatic ins(logic [2:0] o, logic [3:0] s, logic [31:0] v);
    r = rnd();
    // destination kept off the stack pointer and program counter
    ird = 4'(r[15:8] % 8'h0D);
    // source value always comes from an ordinary register
    iv = 1'b1; op = o; isel = s; src = v; imm = r[7:0];
    tick();
    pv = {done, ev, svt, gwe}; gv = gdat; rg = grd; sv = simm; iv = 1'b0;
    tick();
  endtask
  task automatic srcev(logic [4:0] n, logic p, logic d);
    fire = !d; drop = d; line = n; pls = p;
    tick();
    fire = 1'b0; drop = 1'b0;
    tick();
  endtask
  task automatic ret();
    exr = 1'b1;
    tick();
    exr = 1'b0;
    tick();
  endtask
  task automatic wait_irq(logic [4:0] n);
    for (k = 0; k < 20 && seen[5] !== 1'b1; k++) tick();
    chk("irq", {26'h0, 1'b1, n}, {26'h0, seen});
    seen = 6'h00;
  endtask
  task automatic wake();
    for (k = 0; k < 20 && slp !== 1'b0; k++) tick();
    chk("wake", 32'h0, {31'h0, slp});
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) tick();
    rst = 1'b0;
    chk("evreg", 32'h0, {31'h0, evr});
    rd(`SIC_OFF_SET_EN, 32'h0, 1'b0);
    rd(`SIC_OFF_CLR_EN, 32'h0, 1'b0);
    rd(`SIC_OFF_SET_PEND, 32'h0, 1'b0);
    rd(`SIC_OFF_CLR_PEND, 32'h0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      rd(`SIC_OFF_PRIO_BASE + 32'(4 * i), 32'h0, 1'b0);
      t = rnd();
      bus(1'b1, `SIC_OFF_PRIO_BASE + 32'(4 * i), t);
      rd(`SIC_OFF_PRIO_BASE + 32'(4 * i), t & 32'hC0C0C0C0, 1'b0);
    end
    rd(32'hE000E500, 32'h0, 1'b1);
    t = rnd();
    ins(sic_pkg::SIC_OP_SRWRITE, `SIC_SR_SEL_APP_STATUS_VIEW, t);
    chk("flags", {28'h0, t[31:28]}, {28'h0, flg});
    for (int i = 1; i < 7; i++) begin
      if (i == 2) continue;
      ins(3'(i), `SIC_SR_SEL_APP_STATUS_VIEW, rnd());
      chk("pulses", {28'h0, pulses(3'(i))}, {28'h0, pv});
      chk("flags", {28'h0, t[31:28]}, {28'h0, flg});
      if (i == 1)
        chk("mrs", {t[31:28], 24'h0, ird}, {gv[31:28], 24'h0, rg});
      if (i == 4) chk("evreg", 32'h1, {31'h0, evr});
      if (i == 5) chk("svcimm", {24'h0, imm}, {24'h0, sv});
      if (i == 5) ret();
      if (i == 6) chk("nosleep", 32'h0, {31'h0, slp});
    end
    t = rnd();
    ins(sic_pkg::SIC_OP_SRWRITE, `SIC_SR_SEL_MSP, t);
    chk("msp", t & 32'hFFFFFFFC, main_stack_pointer);
    ins(sic_pkg::SIC_OP_SRREAD, `SIC_SR_SEL_MSP, 32'h0);
    chk("mrsmsp", t & 32'hFFFFFFFC, gv);
    ins(sic_pkg::SIC_OP_SRWRITE, `SIC_SR_SEL_MASK, 32'h1);
    ins(sic_pkg::SIC_OP_SRREAD, `SIC_SR_SEL_MASK, 32'h0);
    chk("mask", 32'h3, {gv[30:0], msk});
    bus(1'b1, `SIC_OFF_PRIO_BASE, 32'h80000000);
    bus(1'b1, `SIC_OFF_PRIO_BASE + 32'h4, 32'h00004000);
    bus(1'b1, `SIC_OFF_SET_EN, 32'h28);
    bus(1'b1, `SIC_OFF_CLR_EN, 32'h08);
    rd(`SIC_OFF_SET_EN, 32'h20, 1'b0);
    bus(1'b1, `SIC_OFF_SET_EN, 32'h28);
    ins(sic_pkg::SIC_OP_WIRQ, 4'h0, 32'h0);
    chk("sleep", 32'h1, {31'h0, slp});
    srcev(5'd5, 1'b1, 1'b0);
    wake();
    srcev(5'd3, 1'b0, 1'b0);
    repeat (4) tick();
    rd(`SIC_OFF_SET_PEND, 32'h28, 1'b0);
    chk("masked", 32'h0, {26'h0, seen});
    ins(sic_pkg::SIC_OP_SRWRITE, `SIC_SR_SEL_MASK, 32'h0);
    wait_irq(5'd5);
    bus(1'b1, `SIC_OFF_CLR_PEND, 32'h20);
    chk("active", 32'h1, {31'h0, act[5]});
    ret();
    wait_irq(5'd3);
    srcev(5'd3, 1'b0, 1'b1);
    repeat (4) tick();
    ret();
    srcev(5'd7, 1'b1, 1'b0);
    repeat (6) tick();
    rd(`SIC_OFF_SET_PEND, 32'h80, 1'b0);
    chk("disabled", 32'h0, {26'h0, seen});
    bus(1'b1, `SIC_OFF_CLR_PEND, 32'h80);
    rd(`SIC_OFF_CLR_PEND, 32'h0, 1'b0);
    ins(sic_pkg::SIC_OP_WIRQ, 4'h0, 32'h0);
    dreq = 1'b1;
    wake();
    dreq = 1'b0;
    tally_and_finish();
  end
endmodule // sic_core_tb

// ==== sic_irq_src.sv ====
// behavioural model of the peripheral interrupt sources
`timescale 1ns/1ps
module sic_irq_src #(
  parameter int NUM_IRQ = 32
) (
  input wire logic clk_in,
  input wire logic fire_in,
  input wire logic pulse_in,
  input wire logic drop_in,
  input wire logic [4:0] line_in,
  output logic [NUM_IRQ-1:0] irq_out
);
  logic [NUM_IRQ-1:0] lvl_q = '0;
  logic [NUM_IRQ-1:0] pls_q = '0;
  always @(posedge clk_in) begin
    if (fire_in && !pulse_in) lvl_q[line_in] <= 1'b1;
    if (drop_in) lvl_q[line_in] <= 1'b0;
  end
  always @(posedge clk_in) begin
    pls_q <= '0;
    if (fire_in && pulse_in) pls_q[line_in] <= 1'b1;
  end
  assign irq_out = lvl_q | pls_q;
endmodule // sic_irq_src

// ==== sic_pkg.sv ====
// types shared by the system-instruction block
package sic_pkg;
  typedef enum logic [2:0] {
    SIC_OP_NONE = 3'h0,
    SIC_OP_SRREAD = 3'h1,
    SIC_OP_SRWRITE = 3'h2,
    SIC_OP_NOP = 3'h3,
    SIC_OP_SEV = 3'h4,
    SIC_OP_SVC = 3'h5,
    SIC_OP_WEVT = 3'h6,
    SIC_OP_WIRQ = 3'h7
  } sic_op_type;
  typedef enum logic [0:0] {
    SIC_ST_RUN = 1'b0,
    SIC_ST_SLEEP = 1'b1
  } sic_state_type;
endpackage
